//--- logic/fsyn_pkg.sv
// constants, field layout and types for the synthesizer control block
// assumes one 250 MHz system clock; serial pins arrive already synchronous
// Operation
// - Reference divided by a 4-bit counter, ratios 1 to 15, into the comparison clock.
// - A 12-bit fraction modulus sets comparison frequency over channel step.
// - Modulus is staged by a reference-divider write, made active by a main-divider write.
// - Address bits 10 route the word to the control register.
// - Address bits 11 route the word to the noise-and-spur register.
// - Address bits 00 select main divider, 01 select reference divider.
// - Control bit 2 high holds all synthesizer counters in reset.
// - Control bit 3 high puts the charge pump output in high impedance.
// - Control bit 4 high powers down; registers keep their contents.
// - Power-down forces counters to load state, pump high-Z, lock detect reset.
// - Serial input register keeps shifting and latching during power-down.
// - Lock needs 24 good comparison cycles, or 40 with precision bit set.
// - Control bit 6 selects phase detector polarity, 1 for positive slope.
// - Control bits 7 to 10 select the charge pump current.
// - Doubler bit 0: falling reference edge only; 1: both edges active.
// - Modes: low spur dithers, low noise-and-spur no dither, lowest noise also pump region.
// - Word 0003C7 to the noise-and-spur register selects lowest noise mode.
// - Load-control bit high: modulus field becomes resync delay, staged modulus kept.
// - Output is integer plus fraction over modulus times comparison frequency.
package fsyn_pkg;
   // serial word
   localparam int WORD_W = 24;
   localparam logic [1:0] ADDR_MAIN = 2'h0;
   localparam logic [1:0] ADDR_REF = 2'h1;
   localparam logic [1:0] ADDR_CTRL = 2'h2;
   localparam logic [1:0] ADDR_NOISE = 2'h3;
   // main divider fields
   localparam int MAIN_FRACTION_NUMERATOR_LSB = 2;
   localparam int MAIN_INT_LSB = 14;
   localparam int MAIN_FASTLOCK_BIT = 23;
   // reference divider fields
   localparam int REF_MOD_LSB = 2;
   localparam int REF_RCNT_LSB = 14;
   localparam int REF_PRESC_BIT = 18;
   localparam int REF_MUX_LSB = 20;
   localparam int REF_LOAD_BIT = 23;
   // control fields
   localparam int CTRL_CNT_RST_BIT = 2;
   localparam int CTRL_CP_TRI_BIT = 3;
   localparam int CTRL_PDOWN_BIT = 4;
   localparam int CTRL_LDP_BIT = 5;
   localparam int CTRL_PD_POL_BIT = 6;
   localparam int CTRL_CP_CUR_LSB = 7;
   localparam int CTRL_DOUBLER_BIT = 11;
   // noise and spur mode field, bits 11..2 of the word
   localparam int NOISE_MODE_LSB = 2;
   localparam logic [23:0] NOISE_LOWEST_WORD = 24'h00_03c7;
   localparam logic [9:0] NOISE_LOWEST_CODE = NOISE_LOWEST_WORD[11:2];
   localparam logic [9:0] NOISE_LNS_CODE = 10'h0e0;
   // lock detect counts and pump current
   localparam int LOCK_CNT_NORMAL = 24;
   localparam int LOCK_CNT_PRECISE = 40;
   localparam logic [3:0] CP_CUR_MAX = 4'hf;
   // reset values
   localparam logic [23:0] WORD_RESET = 24'h00_0000;
   localparam logic [11:0] MOD_RESET = 12'h000;
   localparam logic [3:0] RCNT_RESET = 4'h1;

   typedef enum logic {FSYN_LD_HUNT, FSYN_LD_LOCKED} fsyn_ld_state_e;
   typedef enum logic [1:0] {FSYN_LOW_SPUR, FSYN_LOW_NOISE_SPUR, FSYN_LOWEST_NOISE} fsyn_mode_e;
endpackage : fsyn_pkg

//--- logic/fsyn_lock_detect.sv
// digital lock detector counting good comparison cycles
// assumes the phase detector supplies per-cycle small and large error flags
module fsyn_lock_detect #(
   parameter int CNT_W = 6
) (
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   // comparison events
   input wire logic i_clear,
   input wire logic i_cmp_tick,
   input wire logic i_err_small,
   input wire logic i_err_large,
   input wire logic i_precision,
   // lock status
   output logic o_locked
);
   import fsyn_pkg::*;

   typedef struct packed {
      fsyn_ld_state_e state;
      logic [CNT_W-1:0] count;
      logic locked;
   } fsyn_ld_s;

   fsyn_ld_s st_reg;
   fsyn_ld_s st_next;
   logic [CNT_W-1:0] target;

   // counter must reach the longer of the two lock counts; refused at elaboration
   if ((2 ** CNT_W) <= LOCK_CNT_PRECISE) begin : g_cnt_w_bad
      $error("fsyn_lock_detect: CNT_W too small");
   end

   // lock target picked by the precision bit
   assign target = i_precision ? CNT_W'(LOCK_CNT_PRECISE)
                               : CNT_W'(LOCK_CNT_NORMAL);

   // next state
   always_comb begin
      st_next = st_reg;
      if (i_clear) begin
         st_next.state = FSYN_LD_HUNT;
         st_next.count = '0;
      end else if (i_cmp_tick) begin
         case (st_reg.state)
            FSYN_LD_HUNT: begin
               if (!i_err_small) begin
                  st_next.count = '0;
               end else if (st_reg.count + 1'b1 >= target) begin
                  st_next.state = FSYN_LD_LOCKED;
                  st_next.count = '0;
               end else begin
                  st_next.count = st_reg.count + 1'b1;
               end
            end
            FSYN_LD_LOCKED: begin
               if (i_err_large) begin
                  st_next.state = FSYN_LD_HUNT;
               end
            end
            default: begin
               st_next.state = FSYN_LD_HUNT;
               st_next.count = '0;
            end
         endcase
      end
      st_next.locked = (st_next.state == FSYN_LD_LOCKED);
   end

   // state register
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st_reg <= '{state: FSYN_LD_HUNT, count: '0, locked: 1'b0};
      end else begin
         st_reg <= st_next;
      end
   end

   assign o_locked = st_reg.locked;
endmodule : fsyn_lock_detect

//--- logic/fsyn_ctrl_regs.sv
// serial programming port, register bank and reference divider of the synthesizer
// assumes serial clock, data, latch enable and reference are synchronous to i_clk_sys
// and at least two system clocks per level; the analog loop sits outside
module fsyn_ctrl_regs #(
   parameter int LOCK_CNT_W = 6
) (
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   // three-wire serial port
   input wire logic i_ser_clk,
   input wire logic i_ser_data,
   input wire logic i_latch_en,
   // reference and phase detector feedback
   input wire logic i_reference_clock_input,
   input wire logic i_phase_err_small,
   input wire logic i_phase_err_large,
   // divider settings
   output logic [8:0] o_int_value,
   output logic [11:0] o_fraction_numerator,
   output logic [11:0] o_fraction_modulus,
   output logic [11:0] o_resync_delay,
   output logic [3:0] o_ref_count,
   output logic o_prescaler_8_9,
   output logic [2:0] o_mux_select,
   // comparison clock
   output logic o_pfd_ref_tick,
   // control outputs
   output logic o_counter_reset,
   output logic o_cp_high_z,
   output logic o_power_down,
   output logic o_pd_polarity_pos,
   output logic [3:0] o_cp_current,
   output logic o_doubler_en,
   output logic o_dither_en,
   output logic o_cp_low_noise,
   output fsyn_pkg::fsyn_mode_e o_noise_mode,
   // lock detect
   output logic o_lock_detect
);
   import fsyn_pkg::*;

   typedef struct packed {
      logic sclk_q;
      logic le_q;
      logic ref_q;
      logic [WORD_W-1:0] shift;
      logic [8:0] int_value;
      logic [11:0] fraction_numerator;
      logic fastlock;
      logic [11:0] staged_mod;
      logic [11:0] active_mod;
      logic [11:0] resync_delay;
      logic [3:0] rcount;
      logic prescaler;
      logic [2:0] mux_sel;
      logic cnt_rst;
      logic cp_tri;
      logic pdown;
      logic lock_precision_select;
      logic pd_pol;
      logic [3:0] cp_cur;
      logic doubler;
      fsyn_mode_e mode;
      logic dither_en;
      logic cp_low_noise;
      logic [3:0] rdiv_cnt;
      logic pfd_tick;
      logic new_channel;
      logic [3:0] cp_out;
      logic cp_hz;
      logic hold;
   } fsyn_regs_s;

   fsyn_regs_s st_reg;
   fsyn_regs_s st_next;
   logic [WORD_W-1:0] word;
   logic latch_strobe;
   logic ref_edge;
   logic [3:0] rdiv_eff;
   logic [9:0] mode_code;
   logic lock_clear;

   // the detector needs room for the longer lock count; refused at elaboration
   if (LOCK_CNT_W < 6) begin : g_lock_w_bad
      $error("fsyn_ctrl_regs: LOCK_CNT_W below 6");
   end

   // latch strobe: rising edge of the sampled latch enable
   assign latch_strobe = i_latch_en & ~st_reg.le_q;
   assign word = st_reg.shift;
   assign mode_code = word[NOISE_MODE_LSB +: 10];

   // active reference edge: both edges when doubling, else falling only
   assign ref_edge = st_reg.doubler ? (i_reference_clock_input ^ st_reg.ref_q)
                                    : (st_reg.ref_q & ~i_reference_clock_input);
   // a zero ratio is illegal; divide by one rather than stall
   assign rdiv_eff = (st_reg.rcount == 4'h0) ? 4'h1 : st_reg.rcount;

   // next state
   always_comb begin
      st_next = st_reg;
      st_next.sclk_q = i_ser_clk;
      st_next.le_q = i_latch_en;
      st_next.ref_q = i_reference_clock_input;
      st_next.new_channel = 1'b0;
      st_next.pfd_tick = 1'b0;

      // shifter never gated by power-down
      if (i_ser_clk && !st_reg.sclk_q) begin
         st_next.shift = {st_reg.shift[WORD_W-2:0], i_ser_data};
      end

      // address decode on the two low bits of the latched word
      if (latch_strobe) begin
         case (word[1:0])
            ADDR_MAIN: begin
               st_next.int_value = word[MAIN_INT_LSB +: 9];
               st_next.fraction_numerator = word[MAIN_FRACTION_NUMERATOR_LSB +: 12];
               st_next.fastlock = word[MAIN_FASTLOCK_BIT];
               st_next.active_mod = st_reg.staged_mod;
               st_next.new_channel = 1'b1;
            end
            ADDR_REF: begin
               if (word[REF_LOAD_BIT]) begin
                  st_next.resync_delay = word[REF_MOD_LSB +: 12];
               end else begin
                  st_next.staged_mod = word[REF_MOD_LSB +: 12];
               end
               st_next.rcount = word[REF_RCNT_LSB +: 4];
               st_next.prescaler = word[REF_PRESC_BIT];
               st_next.mux_sel = word[REF_MUX_LSB +: 3];
            end
            ADDR_CTRL: begin
               st_next.cnt_rst = word[CTRL_CNT_RST_BIT];
               st_next.cp_tri = word[CTRL_CP_TRI_BIT];
               st_next.pdown = word[CTRL_PDOWN_BIT];
               st_next.lock_precision_select = word[CTRL_LDP_BIT];
               st_next.pd_pol = word[CTRL_PD_POL_BIT];
               st_next.cp_cur = word[CTRL_CP_CUR_LSB +: 4];
               st_next.doubler = word[CTRL_DOUBLER_BIT];
            end
            ADDR_NOISE: begin
               if (mode_code == NOISE_LOWEST_CODE) begin
                  st_next.mode = FSYN_LOWEST_NOISE;
               end else if (mode_code == NOISE_LNS_CODE) begin
                  st_next.mode = FSYN_LOW_NOISE_SPUR;
               end else begin
                  st_next.mode = FSYN_LOW_SPUR;
               end
            end
            default: begin
               st_next.mode = st_reg.mode;
            end
         endcase
      end

      // mode side effects registered, so outputs come straight from flops
      case (st_next.mode)
         FSYN_LOWEST_NOISE: begin
            st_next.dither_en = 1'b0;
            st_next.cp_low_noise = 1'b1;
         end
         FSYN_LOW_NOISE_SPUR: begin
            st_next.dither_en = 1'b0;
            st_next.cp_low_noise = 1'b0;
         end
         default: begin
            st_next.dither_en = 1'b1;
            st_next.cp_low_noise = 1'b0;
         end
      endcase

      // power-down overrides the pump and counters but never the stored words
      st_next.hold = st_next.cnt_rst | st_next.pdown;
      st_next.cp_hz = st_next.cp_tri | st_next.pdown;
      // fastlock borrows the largest current for as long as the main-divider fastlock bit stays set
      st_next.cp_out = st_next.fastlock ? CP_CUR_MAX : st_next.cp_cur;

      // reference counter, parked at its load state while held
      if (st_reg.hold) begin
         st_next.rdiv_cnt = 4'h0;
      end else if (ref_edge) begin
         if (st_reg.rdiv_cnt + 4'h1 >= rdiv_eff) begin
            st_next.rdiv_cnt = 4'h0;
            st_next.pfd_tick = 1'b1;
         end else begin
            st_next.rdiv_cnt = st_reg.rdiv_cnt + 4'h1;
         end
      end
   end

   // state register
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st_reg <= '{sclk_q: 1'b0, le_q: 1'b0, ref_q: 1'b0, shift: WORD_RESET,
                     int_value: 9'h000, fraction_numerator: 12'h000, fastlock: 1'b0,
                     staged_mod: MOD_RESET, active_mod: MOD_RESET, resync_delay: 12'h000,
                     rcount: RCNT_RESET, prescaler: 1'b0, mux_sel: 3'h0,
                     cnt_rst: 1'b0, cp_tri: 1'b0, pdown: 1'b0, lock_precision_select: 1'b0, pd_pol: 1'b0,
                     cp_cur: 4'h0, doubler: 1'b0, mode: FSYN_LOW_SPUR, dither_en: 1'b1,
                     cp_low_noise: 1'b0, rdiv_cnt: 4'h0, pfd_tick: 1'b0,
                     new_channel: 1'b0, cp_out: 4'h0, cp_hz: 1'b0, hold: 1'b0};
      end else begin
         st_reg <= st_next;
      end
   end

   // lock detect restarts on reset hold, power-down or a new channel
   assign lock_clear = st_reg.hold | st_reg.new_channel;

   fsyn_lock_detect #(
      .CNT_W(LOCK_CNT_W)
   ) u_lock (
      .i_clk_sys(i_clk_sys),
      .i_rst_n(i_rst_n),
      .i_clear(lock_clear),
      .i_cmp_tick(st_reg.pfd_tick),
      .i_err_small(i_phase_err_small),
      .i_err_large(i_phase_err_large),
      .i_precision(st_reg.lock_precision_select),
      .o_locked(o_lock_detect)
   );

   // outputs, all from the state register
   assign o_int_value = st_reg.int_value;
   assign o_fraction_numerator = st_reg.fraction_numerator;
   assign o_fraction_modulus = st_reg.active_mod;
   assign o_resync_delay = st_reg.resync_delay;
   assign o_ref_count = st_reg.rcount;
   assign o_prescaler_8_9 = st_reg.prescaler;
   assign o_mux_select = st_reg.mux_sel;
   assign o_pfd_ref_tick = st_reg.pfd_tick;
   assign o_counter_reset = st_reg.hold;
   assign o_cp_high_z = st_reg.cp_hz;
   assign o_power_down = st_reg.pdown;
   assign o_pd_polarity_pos = st_reg.pd_pol;
   assign o_cp_current = st_reg.cp_out;
   assign o_doubler_en = st_reg.doubler;
   assign o_dither_en = st_reg.dither_en;
   assign o_cp_low_noise = st_reg.cp_low_noise;
   assign o_noise_mode = st_reg.mode;
endmodule : fsyn_ctrl_regs

//--- tb/fsyn_ctrl_regs_sva.sv
// concurrent checks on the synthesizer control block top ports
// assumes a single clock domain and async active-low reset
module fsyn_ctrl_regs_sva #(
   parameter int LOCK_CNT_W = 6
) (
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   // watched inputs
   input wire logic i_latch_en,
   input wire logic i_phase_err_small,
   input wire logic i_phase_err_large,
   // watched outputs
   input wire logic [11:0] o_fraction_modulus,
   input wire logic [3:0] o_ref_count,
   input wire logic o_pfd_ref_tick,
   input wire logic o_counter_reset,
   input wire logic o_cp_high_z,
   input wire logic o_power_down,
   input wire logic o_dither_en,
   input wire logic o_cp_low_noise,
   input wire fsyn_pkg::fsyn_mode_e o_noise_mode,
   input wire logic o_lock_detect
);
   timeunit 1ns;
   timeprecision 100ps;
   import fsyn_pkg::*;
   typedef struct packed {
      logic [6:0] good_cnt;
   } fsyn_chk_s;
   fsyn_chk_s chk_reg, chk_next;

   // run of good ticks, saturating; a counter, as a repetition of 40 would crawl
   always_comb begin
      chk_next = chk_reg;
      if (o_pfd_ref_tick && !i_phase_err_small) begin
         chk_next.good_cnt = 7'h00;
      end else if (o_pfd_ref_tick && chk_reg.good_cnt != 7'h7f) begin
         chk_next.good_cnt = chk_reg.good_cnt + 7'h01;
      end
   end

   // helper state register
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) chk_reg <= '0;
      else chk_reg <= chk_next;
   end

   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_rst_n);

   // multi-step conditions
   sequence s_pdown_held;
      o_power_down [*4];
   endsequence
   sequence s_rst_held;
      o_counter_reset ##1 o_counter_reset;
   endsequence

   a_pdown_forces: assert property (o_power_down |-> o_counter_reset && o_cp_high_z)
      else $error("power-down without counter reset and pump high-z");
   a_pdown_unlock: assert property (s_pdown_held |-> !o_lock_detect)
      else $error("lock held through power-down");
   a_rst_no_tick: assert property (s_rst_held |-> !o_pfd_ref_tick)
      else $error("reference tick while counters reset");
   a_lock_run: assert property ($rose(o_lock_detect) |->
      chk_reg.good_cnt >= 7'(LOCK_CNT_NORMAL))
      else $error("lock set after too few good ticks");
   a_unlock_large: assert property (
      o_lock_detect && o_pfd_ref_tick && i_phase_err_large |-> ##[1:2] !o_lock_detect)
      else $error("lock kept after large phase error");
   a_mod_on_latch: assert property ($changed(o_fraction_modulus) |-> $past(i_latch_en))
      else $error("modulus changed without latch strobe");
   a_rcnt_on_latch: assert property ($changed(o_ref_count) |-> $past(i_latch_en))
      else $error("reference count changed without latch strobe");
   a_dither_mode: assert property (o_dither_en == (o_noise_mode == FSYN_LOW_SPUR))
      else $error("dither does not follow noise mode");
   a_low_noise_pump: assert property (
      o_cp_low_noise == (o_noise_mode == FSYN_LOWEST_NOISE))
      else $error("pump region does not follow noise mode");
endmodule : fsyn_ctrl_regs_sva

bind fsyn_ctrl_regs fsyn_ctrl_regs_sva #(.LOCK_CNT_W(LOCK_CNT_W)) u_sva (
   .i_clk_sys, .i_rst_n, .i_latch_en, .i_phase_err_small, .i_phase_err_large,
   .o_fraction_modulus, .o_ref_count, .o_pfd_ref_tick, .o_counter_reset, .o_cp_high_z,
   .o_power_down, .o_dither_en, .o_cp_low_noise, .o_noise_mode, .o_lock_detect
);

//--- tb/fsyn_host_model.sv
// host model shifting words into the three-wire programming port
// assumes callers enter send_word just after a rising clock edge
module fsyn_host_model (
   // clock
   input wire logic i_clk_sys,
   // three-wire serial port
   output logic o_ser_clk,
   output logic o_ser_data,
   output logic o_latch_en
);
   timeunit 1ns;
   timeprecision 100ps;

   // serial clock stands still low between frames
   initial begin
      o_ser_clk = 1'b0;
      o_ser_data = 1'b0;
      o_latch_en = 1'b0;
   end

   // every level held two clocks, the fastest the port must accept
   task automatic hold2();
      repeat (2) @(posedge i_clk_sys);
      #1;
   endtask : hold2

   // one word msb first, then the latch strobe
   task automatic send_word(input logic [23:0] w);
      for (int i = 23; i >= 0; i--) begin
         o_ser_data = w[i];
         hold2();
         o_ser_clk = 1'b1;
         hold2();
         o_ser_clk = 1'b0;
      end
      o_ser_data = ~w[0]; // line released, no pull: never the last bit
      hold2();
      o_latch_en = 1'b1;
      hold2();
      o_latch_en = 1'b0;
      hold2();
   endtask : send_word
endmodule : fsyn_host_model

//--- tb/fsyn_ctrl_regs_bench.sv
// self-checking bench for the synthesizer control block
// assumes the host model on the serial port and the bound checker
module fsyn_ctrl_regs_bench;
   timeunit 1ns;
   timeprecision 100ps;
   import fsyn_pkg::*;
   logic i_clk_sys, i_rst_n, ser_clk, ser_data, latch_en, ref_in, err_small, err_large;
   logic [8:0] int_value, iv;
   logic [11:0] fraction_numerator, modulus, resync, m, fr, d, old_m;
   logic [3:0] rcnt, cp_cur, r, pm;
   logic [2:0] mux_sel;
   logic [9:0] b;
   logic presc, tick, cnt_rst, cp_hz, pdown, pol, dbl, dither, cp_ln, lock;
   fsyn_mode_e mode;
   int n_errors = 0, checked = 0, seed = 38376, n_ticks = 0;

   fsyn_ctrl_regs #(.LOCK_CNT_W(6)) u_fsyn_ctrl_regs (
      .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_ser_clk(ser_clk), .i_ser_data(ser_data),
      .i_latch_en(latch_en), .i_reference_clock_input(ref_in), .i_phase_err_small(err_small),
      .i_phase_err_large(err_large), .o_int_value(int_value), .o_fraction_numerator(fraction_numerator),
      .o_fraction_modulus(modulus), .o_resync_delay(resync), .o_ref_count(rcnt),
      .o_prescaler_8_9(presc), .o_mux_select(mux_sel), .o_pfd_ref_tick(tick),
      .o_counter_reset(cnt_rst), .o_cp_high_z(cp_hz), .o_power_down(pdown),
      .o_pd_polarity_pos(pol), .o_cp_current(cp_cur), .o_doubler_en(dbl), .o_dither_en(dither),
      .o_cp_low_noise(cp_ln), .o_noise_mode(mode), .o_lock_detect(lock));
   fsyn_host_model u_fsyn_host_model (.i_clk_sys(i_clk_sys), .o_ser_clk(ser_clk),
      .o_ser_data(ser_data), .o_latch_en(latch_en));

   // clock and tick counter
   initial begin
      i_clk_sys = 1'b0;
      forever #2 i_clk_sys = ~i_clk_sys;
   end
   always @(posedge i_clk_sys) if (tick === 1'b1) n_ticks++;

   task automatic step(input int n);
      repeat (n) @(posedge i_clk_sys);
      #1;
   endtask : step
   task automatic chk(input logic [11:0] got, input logic [11:0] exp, input string what);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk
   task automatic chk_mode(input fsyn_mode_e got, input fsyn_mode_e exp);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED %0t noise mode %0d exp %0d", $time, got, exp);
      end
   endtask : chk_mode
   function automatic fsyn_mode_e exp_mode(input logic [9:0] c);
      if (c == NOISE_LOWEST_CODE) return FSYN_LOWEST_NOISE;
      if (c == NOISE_LNS_CODE) return FSYN_LOW_NOISE_SPUR;
      return FSYN_LOW_SPUR;
   endfunction : exp_mode
   function automatic logic [11:0] exp_ctl(input logic [9:0] c);
      return 12'({c[0] | c[2], c[1] | c[2], c[2]});
   endfunction : exp_ctl
   function automatic logic [23:0] ctrl_w(input logic [9:0] bits);
      return {12'h000, bits, ADDR_CTRL};
   endfunction : ctrl_w
   function automatic logic [23:0] ref_w(input logic ld, input logic [3:0] rc,
      input logic [11:0] mf);
      return {ld, pm[2:0], 1'b0, pm[3], rc, mf, ADDR_REF};
   endfunction : ref_w
   task automatic wr(input logic [23:0] w);
      u_fsyn_host_model.send_word(w);
   endtask : wr
   task automatic pulses(input int n);
      repeat (n) begin
         ref_in = 1'b1;
         step(2);
         ref_in = 1'b0;
         step(2);
      end
      step(4);
   endtask : pulses
   task automatic tally_and_finish();
      $display("errors %0d checks %0d", n_errors, checked);
      if (n_errors == 0 && checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : tally_and_finish
   // lock, then drop it by main write, large error or power-down
   task automatic lock_run(input logic [1:0] how);
      int need;
      need = how[0] ? LOCK_CNT_PRECISE : LOCK_CNT_NORMAL;
      wr(ctrl_w({6'h00, how[0], 3'h0}));
      wr({1'b0, 9'h05b, 12'h000, ADDR_MAIN});
      err_small = 1'b1;
      pulses(need - 1);
      chk(12'(lock), 12'h000, "early lock");
      pulses(1);
      chk(12'(lock), 12'h001, "lock");
      err_small = 1'b0;
      err_large = (how == 2'h1);
      if (how == 2'h1) pulses(1);
      else if (how == 2'h2) wr(ctrl_w(10'h004));
      else wr({1'b0, 9'h05c, 12'h000, ADDR_MAIN});
      chk(12'(lock), 12'h000, "unlock");
      err_large = 1'b0;
   endtask : lock_run

   // watchdog
   initial begin
      step(30000);
      n_errors++;
      $display("CHECK FAILED %0t watchdog", $time);
      tally_and_finish();
   end

   // main sequence
   initial begin
      i_rst_n = 1'b0;
      {ref_in, err_small, err_large, pm} = '0;
      old_m = MOD_RESET;
      step(5);
      i_rst_n = 1'b1;
      step(1);
      chk(12'({rcnt, dither, cp_cur}), 12'h030, "reset values");
      chk(modulus, MOD_RESET, "reset modulus");
      chk_mode(mode, FSYN_LOW_SPUR);
      for (int i = 0; i < 4; i++) begin
         b = (i == 0) ? 10'h000 : (i == 1) ? NOISE_LOWEST_CODE : 10'($random(seed));
         if (i == 2) b = NOISE_LNS_CODE;
         wr({12'h000, b, ADDR_NOISE});
         chk_mode(mode, exp_mode(b));
         chk(12'({dither, cp_ln}), 12'({exp_mode(b) == FSYN_LOW_SPUR,
            exp_mode(b) == FSYN_LOWEST_NOISE}), "dither and pump");
      end
      repeat (6) begin
         b = 10'($random(seed));
         wr(ctrl_w(b));
         chk(12'({cnt_rst, cp_hz, pdown}), exp_ctl(b), "ctl");
         chk(12'({pol, cp_cur, dbl}), 12'({b[4], b[8:5], b[9]}), "fields");
      end
      wr(ctrl_w(10'h001));
      repeat (3) begin
         m = 12'($random(seed)) | 12'h002;
         r = 4'($random(seed));
         pm = 4'($random(seed));
         iv = 9'($random(seed));
         if (iv < (pm[3] ? 9'h05b : 9'h01f)) iv = pm[3] ? 9'h05b : 9'h01f;
         fr = m & 12'($random(seed));
         d = 12'($random(seed));
         wr(ref_w(1'b0, r, m));
         chk(12'({presc, mux_sel, rcnt}), 12'({pm, r}), "ref fields");
         chk(modulus, old_m, "staged modulus");
         wr({1'b0, iv, fr, ADDR_MAIN});
         chk(modulus, m, "active modulus");
         chk({int_value, 3'h0}, {iv, 3'h0}, "int");
         chk(fraction_numerator, fr, "fraction_numerator");
         wr(ref_w(1'b1, r, d));
         chk(resync, d, "resync delay");
         wr({1'b0, iv, fr, ADDR_MAIN});
         chk(modulus, m, "modulus kept");
         old_m = m;
      end
      wr(ctrl_w(10'h000));
      for (int i = 0; i < 4; i++) begin
         r = 4'(i * 5);
         wr(ctrl_w({i[0], 8'h00, 1'b1}));
         wr(ref_w(1'b0, r, old_m));
         n_ticks = 0;
         pulses(2);
         chk(12'(n_ticks), 12'h000, "ticks in reset");
         wr(ctrl_w({i[0], 9'h000}));
         n_ticks = 0;
         pulses(2 * ((r == 4'h0) ? 1 : int'(r)));
         chk(12'(n_ticks), 12'(2 + 2 * i[0]), "tick count");
      end
      wr(ref_w(1'b0, 4'h1, old_m));
      lock_run(2'h0);
      lock_run(2'h1);
      lock_run(2'h2);
      b = {1'b0, 4'($random(seed)), 5'h04};
      wr(ctrl_w(b));
      chk(12'({cnt_rst, cp_hz, pdown}), 12'h007, "power-down");
      wr({1'b0, 9'h1ff, 12'h000, ADDR_MAIN});
      chk({int_value, 3'h0}, 12'hff8, "load in power-down");
      n_ticks = 0;
      pulses(2);
      chk(12'(n_ticks), 12'h000, "ticks in power-down");
      wr(ctrl_w(b & 10'h3fb));
      chk(12'({pdown, cp_cur}), 12'(b[8:5]), "kept current");
      chk(modulus, old_m, "modulus after power-down");
      wr({1'b1, 9'h05b, 12'h000, ADDR_MAIN});
      chk(12'(cp_cur), 12'(CP_CUR_MAX), "fastlock");
      tally_and_finish();
   end
endmodule : fsyn_ctrl_regs_bench
